// File: common/ipsm_pkg.sv
// Shared constants for the idle power-state manager.
package ipsm_pkg;
  // ==========================================================================
  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] IPSM_CTRL      = 8'h00;
  localparam logic [7:0] IPSM_RELOAD_EN = 8'h04;
  localparam logic [7:0] IPSM_DOZE_T    = 8'h08;
  localparam logic [7:0] IPSM_STBY_T    = 8'h0c;
  localparam logic [7:0] IPSM_SUSP_T    = 8'h10;
  localparam logic [7:0] IPSM_DISK_T    = 8'h14;
  localparam logic [7:0] IPSM_STATUS    = 8'h18;
  localparam logic [7:0] IPSM_IRQ_STAT  = 8'h1c;
  localparam logic [7:0] IPSM_IRQ_MASK  = 8'h20;
  // ==========================================================================
  // Control register field positions.
  localparam int CTL_LEVEL_LO   = 0;  // Two bits: saving level.
  localparam int CTL_DOZE_EN    = 2;
  localparam int CTL_STBY_EN    = 3;
  localparam int CTL_SUSP_EN    = 4;
  localparam int CTL_DISK_EN    = 5;
  localparam int CTL_SYNC_BLANK = 6;  // One: sync off plus blank; zero: blank only.
  localparam int CTL_VIDMON_EN  = 7;
  localparam int CTL_SOFTOFF_EN = 8;
  localparam int CTL_RING_EN    = 9;
  localparam int CTL_ALARM_EN   = 10;
  localparam int CTL_RTCIRQ_EN  = 11;
  localparam int CTL_CSLEEP_EN  = 12;
  localparam int CTL_THERM_EN   = 13;
  localparam int CTL_THR_LO     = 16; // Three bits: throttle duty in eighths minus one.
  localparam logic [31:0] CTRL_RESET = 32'h0004_0000; // Saving off, 62.5% duty.
  // ==========================================================================
  // Saving levels.
  localparam logic [1:0] LVL_OFF  = 2'h0;
  localparam logic [1:0] LVL_MIN  = 2'h1;
  localparam logic [1:0] LVL_MAX  = 2'h2;
  localparam logic [1:0] LVL_USER = 2'h3;
  // Preset idle times in ticks; the presets differ only in these delays.
  localparam logic [15:0] MIN_DOZE = 16'h9c40;
  localparam logic [15:0] MIN_STBY = 16'hc350;
  localparam logic [15:0] MIN_SUSP = 16'hea60;
  localparam logic [15:0] MIN_DISK = 16'hea60;
  localparam logic [15:0] MAX_DOZE = 16'h03e8;
  localparam logic [15:0] MAX_STBY = 16'h07d0;
  localparam logic [15:0] MAX_SUSP = 16'h0fa0;
  localparam logic [15:0] MAX_DISK = 16'h0fa0;
  localparam logic [15:0] USER_T_RESET = 16'hea60;
  // IRQ lines usable as reload sources: 3..7 and 9..15.
  localparam logic [15:0] RELOAD_IRQ_OK = 16'hfef8;
  // ==========================================================================
  // Timing: one idle tick is one millisecond of a 125 MHz clock.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int SOFT_OFF_S    = 4;
  localparam int SOFT_OFF_MS   = SOFT_OFF_S * 1000;
  // Interrupt status bits.
  localparam int EV_DOZE = 0;
  localparam int EV_STBY = 1;
  localparam int EV_SUSP = 2;
  localparam int EV_DISK = 3;
  localparam int EV_WAKE = 4;
  localparam int EV_OFF  = 5;
  localparam int EV_N    = 6;
  // Power states.
  typedef enum logic [2:0] {ST_FULL, ST_DOZE, ST_STBY, ST_SUSP, ST_OFF} ipsm_state_t;
endpackage

// File: core/ipsm_top.sv
// Idle power-state manager with a Wishbone register slave.
// How it works
// RULE_01: Level is off, min, max or user.
// RULE_02: Idle times writable only in user level.
// RULE_03: Each enabled state entered after its idle time.
// RULE_04: Light state slows cpu, all else active.
// RULE_05: Standby slows cpu, disks and video off.
// RULE_06: Suspend halts all but memory refresh.
// RULE_07: Disk timer shuts only the disks.
// RULE_08: Throttle picks slowed fraction, 62.5% selectable.
// RULE_09: Cache sleep in suspend when enabled only.
// RULE_10: Cache sleep low during stop grant.
// RULE_11: Video activity restarts standby timer when enabled.
// RULE_12: Button held 4 s powers board off.
// RULE_13: Serial ring wakes from any state; the code never leaves the off state on a ring.
// RULE_14: Clock alarm wakes when enabled.
// RULE_15: Clock interrupt breaks suspend when enabled.
// RULE_16: Enabled reload events restart standby timer.
// RULE_17: Video off blanks, optionally stops sync.
// RULE_18: Fan running plus thermal enable throttles cpu.
// RULE_19: Wake restores clock, peripherals, timers zero.
//
// The Wishbone slave port and the address map were left to the implementer.
module ipsm_top
  import ipsm_pkg::*;
#(
  parameter int TICK_LEN = ipsm_pkg::TICK_CYCLES  // Clock cycles per idle tick.
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Activity and wake sources.
  input  wire logic        sys_activity,
  input  wire logic        video_activity,
  input  wire logic [15:0] irq_lines,
  input  wire logic        nmi,
  input  wire logic [3:0]  ide_activity,
  input  wire logic        floppy_activity,
  input  wire logic        serial_activity,
  input  wire logic        parallel_activity,
  input  wire logic        ring_detect,
  input  wire logic        rtc_alarm,
  input  wire logic        rtc_irq,
  input  wire logic        power_button_input,
  input  wire logic        fan_on,
  // Processor stop-clock handshake.
  input  wire logic        clk_ctl_ack,
  input  wire logic        stop_grant,
  // Power controls.
  output logic             cpu_slow,
  output logic             cpu_halt,
  output logic             disk_off,
  output logic             video_blank,
  output logic             sync_off,
  output logic             periph_off,
  output logic             mem_refresh_en,
  output logic             cache_sleep,
  output logic             power_off,
  output logic             irq
);
  import ipsm_pkg::*;

  // ==========================================================================
  // Register storage.
  logic [31:0]     ctrl;          // Level, enables and throttle setting.
  logic [22:0]     reload_en;     // Reload enables per source; ide_activity[0] and ide_activity[1] share bit 17.
  logic [15:0]     user_doze;     // User idle times, in ticks.
  logic [15:0]     user_stby;
  logic [15:0]     user_susp;
  logic [15:0]     user_disk;
  logic [EV_N-1:0] irq_stat;      // Sticky events.
  logic [EV_N-1:0] irq_mask;      // One lets the event through.
  ipsm_state_t     state;         // Current power state.
  logic [15:0]     idle_cnt;      // Ticks since last activity.
  logic [15:0]     disk_cnt;      // Ticks since last disk activity.
  logic            disk_down;     // Disk timer has expired.
  logic [31:0]     tick_cnt;      // Prescaler for the tick.
  logic            tick;          // One cycle per tick.
  logic [15:0]     btn_cnt;       // Ticks the button has been held.
  logic [2:0]      phase;         // Throttle phase in eighths.
  logic [EV_N-1:0] ev;            // Events of this cycle.
  logic [15:0]     t_doze;        // Effective idle times.
  logic [15:0]     t_stby;
  logic [15:0]     t_susp;
  logic [15:0]     t_disk;
  logic [31:0]     rd_data;
  ipsm_state_t     next_state;

  wire logic [1:0] level   = ctrl[CTL_LEVEL_LO +: 2];
  wire logic [2:0] thr_sel = ctrl[CTL_THR_LO +: 3];
  wire logic       wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic       wb_wr   = wb_req && wb_we_i;

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Picks the preset or user time for the current level.
  function automatic logic [15:0] pick(input logic [1:0] lv, input logic [15:0] mn,
                                       input logic [15:0] mx, input logic [15:0] us);
    case (lv)
      LVL_MIN:  return mn;
      LVL_MAX:  return mx;
      default:  return us;
    endcase
  endfunction

  // ==========================================================================
  // Effective idle times: presets at min and max levels, user times at user and off levels.
  always_comb begin
    t_doze = pick(level, MIN_DOZE, MAX_DOZE, user_doze); // [RULE_01]
    t_stby = pick(level, MIN_STBY, MAX_STBY, user_stby); // [RULE_01]
    t_susp = pick(level, MIN_SUSP, MAX_SUSP, user_susp);
    t_disk = pick(level, MIN_DISK, MAX_DISK, user_disk);
  end

  // ==========================================================================
  // Activity, reload and wake decoding.
  wire logic [6:0] dev_act = {parallel_activity, serial_activity, floppy_activity,
                              ide_activity};
  wire logic reload_hit = |(irq_lines & reload_en[15:0] & RELOAD_IRQ_OK)
                        | (nmi & reload_en[16])
                        | |(dev_act[6:0] & {reload_en[22:17], 1'b0})
                        | (ide_activity[0] & reload_en[17]); // [RULE_16]
  wire logic vid_hit  = video_activity && ctrl[CTL_VIDMON_EN]; // [RULE_11]
  wire logic ext_wake = (ring_detect && ctrl[CTL_RING_EN])           // [RULE_13]
                      || (rtc_alarm && ctrl[CTL_ALARM_EN])           // [RULE_14]
                      || (rtc_irq && ctrl[CTL_RTCIRQ_EN]);           // [RULE_15]
  // Anything that restarts the idle timer also brings the system back up, except from the off state.
  wire logic wake = sys_activity || reload_hit || vid_hit || ext_wake;
  wire logic disk_act = |ide_activity || wake;

  // ==========================================================================
  // Tick prescaler; long idle times count ticks, not clocks.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt == 32'(TICK_LEN - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // ==========================================================================
  // Idle counters; a wake clears both so every state starts afresh.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt <= 16'h0000;
      disk_cnt <= 16'h0000;
    end else begin
      if (wake) begin
        idle_cnt <= 16'h0000; // [RULE_19] [RULE_16] [RULE_11]
      end else if (tick && idle_cnt != 16'hffff) begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
      if (disk_act) begin
        disk_cnt <= 16'h0000;
      end else if (tick && disk_cnt != 16'hffff) begin
        disk_cnt <= disk_cnt + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Deepest enabled state whose idle time has run out; idle moves only go deeper, a wake returns to full.
  always_comb begin
    next_state = state;
    case (state)
      ST_FULL, ST_DOZE, ST_STBY: begin
        if (level != LVL_OFF) begin
          if (ctrl[CTL_SUSP_EN] && idle_cnt >= t_susp) begin
            next_state = ST_SUSP; // [RULE_03]
          end else if (ctrl[CTL_STBY_EN] && idle_cnt >= t_stby && state != ST_STBY) begin
            next_state = ST_STBY; // [RULE_03]
          end else if (ctrl[CTL_DOZE_EN] && idle_cnt >= t_doze && state == ST_FULL) begin
            next_state = ST_DOZE; // [RULE_03]
          end
        end
        if (wake) begin
          next_state = ST_FULL; // [RULE_19]
        end
      end
      ST_SUSP: begin
        if (wake) begin
          next_state = ST_FULL; // [RULE_19] [RULE_15]
        end
      end
      ST_OFF:  next_state = ST_OFF;
      default: next_state = ST_FULL;
    endcase
    if (btn_cnt >= 16'(SOFT_OFF_MS) && ctrl[CTL_SOFTOFF_EN]) begin
      next_state = ST_OFF; // [RULE_12]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_FULL;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Power button hold timer; a release restarts the count.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      btn_cnt <= 16'h0000;
    end else if (!power_button_input || !ctrl[CTL_SOFTOFF_EN]) begin
      btn_cnt <= 16'h0000;
    end else if (tick && btn_cnt < 16'(SOFT_OFF_MS)) begin
      btn_cnt <= btn_cnt + 16'h0001; // [RULE_12]
    end
  end

  // ==========================================================================
  // Disk timer latch, separate from the state ladder.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      disk_down <= 1'b0;
    end else if (disk_act || level == LVL_OFF || !ctrl[CTL_DISK_EN]) begin
      disk_down <= 1'b0; // [RULE_19]
    end else if (disk_cnt >= t_disk) begin
      disk_down <= 1'b1; // [RULE_07]
    end
  end

  // ==========================================================================
  // Throttle phase: the cpu is slowed for thr_sel+1 eighths of each cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  wire logic thr_on = (phase <= thr_sel); // [RULE_08]

  // ==========================================================================
  // Power control outputs, all registered.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_slow       <= 1'b0;
      cpu_halt       <= 1'b0;
      disk_off       <= 1'b0;
      video_blank    <= 1'b0;
      sync_off       <= 1'b0;
      periph_off     <= 1'b0;
      mem_refresh_en <= 1'b1;
      cache_sleep    <= 1'b0;
      power_off      <= 1'b0;
    end else begin
      // Light and standby states slow the cpu; thermal throttling may add to it.
      cpu_slow <= ((state == ST_DOZE || state == ST_STBY) && thr_on)      // [RULE_04] [RULE_05]
                || (state == ST_FULL && ctrl[CTL_THERM_EN] && fan_on && thr_on); // [RULE_18]
      cpu_halt    <= (state == ST_SUSP || state == ST_OFF); // [RULE_06]
      disk_off    <= (state == ST_STBY || state == ST_SUSP || disk_down); // [RULE_05] [RULE_07]
      video_blank <= (state == ST_STBY || state == ST_SUSP); // [RULE_17]
      sync_off    <= (state == ST_STBY || state == ST_SUSP) && ctrl[CTL_SYNC_BLANK]; // [RULE_17]
      periph_off  <= (state == ST_SUSP || state == ST_OFF); // [RULE_06]
      // Refresh keeps running in suspend so memory contents survive.
      mem_refresh_en <= (state != ST_OFF); // [RULE_06]
      // The cache cannot be snooped while asleep, so stop grant forces it awake.
      cache_sleep <= ctrl[CTL_CSLEEP_EN] && state == ST_SUSP && clk_ctl_ack // [RULE_09]
                   && !stop_grant; // [RULE_10]
      power_off   <= (state == ST_OFF); // [RULE_12]
    end
  end

  // ==========================================================================
  // Events for the interrupt status.
  always_comb begin
    ev          = '0;
    ev[EV_DOZE] = (next_state == ST_DOZE) && (state != ST_DOZE);
    ev[EV_STBY] = (next_state == ST_STBY) && (state != ST_STBY);
    ev[EV_SUSP] = (next_state == ST_SUSP) && (state != ST_SUSP);
    ev[EV_DISK] = !disk_down && !disk_act && level != LVL_OFF && ctrl[CTL_DISK_EN]
                  && disk_cnt >= t_disk;
    ev[EV_WAKE] = (next_state == ST_FULL) && (state != ST_FULL);
    ev[EV_OFF]  = (next_state == ST_OFF) && (state != ST_OFF);
  end

  // ==========================================================================
  // Register writes; user times accept writes only at the user level.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl      <= CTRL_RESET;
      reload_en <= '0;
      user_doze <= USER_T_RESET;
      user_stby <= USER_T_RESET;
      user_susp <= USER_T_RESET;
      user_disk <= USER_T_RESET;
      irq_mask  <= '0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        IPSM_CTRL:      ctrl      <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0007_3fff;
        IPSM_RELOAD_EN: reload_en <= 23'(merge(32'(reload_en), wb_dat_i, wb_sel_i));
        IPSM_IRQ_MASK:  irq_mask  <= EV_N'(merge(32'(irq_mask), wb_dat_i, wb_sel_i));
        IPSM_DOZE_T: begin
          if (level == LVL_USER) begin
            user_doze <= 16'(merge(32'(user_doze), wb_dat_i, wb_sel_i)); // [RULE_02]
          end
        end
        IPSM_STBY_T: begin
          if (level == LVL_USER) begin
            user_stby <= 16'(merge(32'(user_stby), wb_dat_i, wb_sel_i)); // [RULE_02]
          end
        end
        IPSM_SUSP_T: begin
          if (level == LVL_USER) begin
            user_susp <= 16'(merge(32'(user_susp), wb_dat_i, wb_sel_i)); // [RULE_02]
          end
        end
        IPSM_DISK_T: begin
          if (level == LVL_USER) begin
            user_disk <= 16'(merge(32'(user_disk), wb_dat_i, wb_sel_i)); // [RULE_02]
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Sticky status: a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat <= '0;
    end else if (wb_wr && wb_adr_i == IPSM_IRQ_STAT && wb_sel_i[0]) begin
      irq_stat <= (irq_stat & ~wb_dat_i[EV_N-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // Read mux; unmapped offsets read zero.
  always_comb begin
    case (wb_adr_i)
      IPSM_CTRL:      rd_data = ctrl;
      IPSM_RELOAD_EN: rd_data = 32'(reload_en);
      IPSM_DOZE_T:    rd_data = {16'h0000, t_doze};
      IPSM_STBY_T:    rd_data = {16'h0000, t_stby};
      IPSM_SUSP_T:    rd_data = {16'h0000, t_susp};
      IPSM_DISK_T:    rd_data = {16'h0000, t_disk};
      IPSM_STATUS:    rd_data = {12'h000, disk_down, state, idle_cnt};
      IPSM_IRQ_STAT:  rd_data = 32'(irq_stat);
      IPSM_IRQ_MASK:  rd_data = 32'(irq_mask);
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  // Every request, mapped or not, is acknowledged one cycle after it arrives.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end
endmodule

// File: dv/ipsm_top_properties.sv
// Concurrent checks on the ports of the idle power-state manager.
module ipsm_top_checker (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Bus and power pins watched.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sys_activity,
  input wire logic        stop_grant,
  input wire logic        cpu_halt,
  input wire logic        disk_off,
  input wire logic        video_blank,
  input wire logic        sync_off,
  input wire logic        mem_refresh_en,
  input wire logic        cache_sleep,
  input wire logic        power_off
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A fresh request: strobe up while no answer is pending.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // A wake that cannot be masked by the off state.
  sequence s_wake;
    sys_activity && !power_off;
  endsequence
  property p_ack;        s_req |=> wb_ack_o; endproperty
  property p_ack_pulse;  wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_zero;   !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_grant;      stop_grant |=> !cache_sleep; endproperty
  property p_refresh;    cpu_halt && !power_off |-> mem_refresh_en; endproperty
  property p_off;        power_off |=> power_off; endproperty
  property p_sync;       sync_off |-> video_blank; endproperty
  property p_stby;       video_blank |-> disk_off; endproperty
  property p_wake;       s_wake |-> ##2 (!cpu_halt && !video_blank); endproperty
  a_ack:       assert property (p_ack)       else $error("no ack one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
  a_dat_zero:  assert property (p_dat_zero)  else $error("read data not zero outside ack");
  a_grant:     assert property (p_grant)     else $error("cache sleep during stop grant");
  a_refresh:   assert property (p_refresh)   else $error("refresh stopped in suspend");
  a_off:       assert property (p_off)       else $error("power off not sticky");
  a_sync:      assert property (p_sync)      else $error("sync off without blank");
  a_stby:      assert property (p_stby)      else $error("video off with disks on");
  a_wake:      assert property (p_wake)      else $error("wake did not restore");
endmodule

// File: dv/ipsm_cpu_model.sv
// Behavioural model of the processor stop-clock side.
module ipsm_cpu_model (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Requests from the manager and the bench.
  input  wire logic cpu_halt,
  input  wire logic grant_req,
  // Handshake back to the manager.
  output logic      clk_ctl_ack,
  output logic      stop_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // The cpu enters clock-control mode one cycle after halt is asked; it only
  // grants the stop when the bench asks, so both cases can be exercised.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_ctl_ack <= 1'b0;
      stop_grant  <= 1'b0;
    end else begin
      clk_ctl_ack <= cpu_halt;
      stop_grant  <= cpu_halt & grant_req;
    end
  end
endmodule

// File: dv/ipsm_top_bench.sv
// Self-checking bench for the idle power-state manager.
module ipsm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ipsm_pkg::*;
  // ==========================================================================
  localparam int TL = 4;  // Short tick keeps the run brief.
  logic        ref_clk = 1'b0, sys_rst = 1'b1;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, sys_activity = 0, video_activity = 0, nmi = 0, floppy_activity = 0;
  logic [15:0] irq_lines = 16'h0;
  logic [3:0]  ide_activity = 4'h0;
  logic        serial_activity = 0, parallel_activity = 0, ring_detect = 0, rtc_alarm = 0;
  logic        rtc_irq = 0, power_button_input = 0, fan_on = 0, grant_req = 0;
  logic        clk_ctl_ack, stop_grant, cpu_slow, cpu_halt, disk_off, video_blank;
  logic        sync_off, periph_off, mem_refresh_en, cache_sleep, power_off, irq;
  int          err_total = 0, compares = 0, k, cnt;
  int          user_t[4];  // Model of the user idle times.
  always #4 ref_clk = ~ref_clk;
  ipsm_top #(.TICK_LEN(TL)) i_ipsm_top (.*);
  ipsm_cpu_model i_ipsm_cpu_model (.*);
  // ==========================================================================
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single Wishbone cycle; waits for ack under a bound.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 50) begin
      err_total++;
      give_verdict();
    end
  endtask
  // Polls the state field until it reaches the wanted value.
  task automatic wait_state(input logic [2:0] st);
    int n;
    n = 0;
    do begin
      wb(0, IPSM_STATUS, 0);
      n++;
    end while (q[18:16] !== st && n < 400);
    chk("state", {29'h0, q[18:16]}, {29'h0, st});
  endtask
  // ==========================================================================
  initial begin
    void'($urandom(34575));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wb(0, IPSM_CTRL, 0);     chk("ctrl reset", q, CTRL_RESET);
    wb(0, 8'h24, 0);         chk("unmapped", q, 32'h0);
    wb(0, IPSM_IRQ_MASK, 0); chk("mask reset", q, 32'h0);
    // Presets apply at min and max levels; only user level takes a written time.
    user_t = '{16'hea60, 16'hea60, 16'hea60, 16'hea60};
    for (int lv = 1; lv < 4; lv++) begin
      wb(1, IPSM_CTRL, 32'(lv));
      wb(1, IPSM_DOZE_T, 32'h3);
      if (lv == 3) user_t[0] = 3;
      wb(0, IPSM_DOZE_T, 0);
      chk("doze time", q, lv == 1 ? MIN_DOZE : lv == 2 ? MAX_DOZE : user_t[0]);
    end
    wb(1, IPSM_STBY_T, 32'h8);
    wb(1, IPSM_SUSP_T, 32'he);
    wb(1, IPSM_IRQ_MASK, 32'h1);
    wb(1, IPSM_RELOAD_EN, {16'h0, RELOAD_IRQ_OK});
    // Activity keeps the idle count at zero.
    sys_activity <= 1'b1;
    wb(1, IPSM_CTRL, 32'h0004_175f);
    sys_activity <= 1'b0;
    wait_state(3'h1);
    repeat (3) @(posedge ref_clk);
    chk("doze video", {disk_off, video_blank, cpu_halt}, 3'b000);
    chk("irq", irq, 1'b1);
    wb(0, IPSM_IRQ_STAT, 0); chk("doze event", q[0], 1'b1);
    wb(1, IPSM_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq clear", irq, 1'b0);
    wait_state(3'h2);
    repeat (2) @(posedge ref_clk);
    chk("standby", {disk_off, video_blank, sync_off}, 3'b111);
    wait_state(3'h3);
    repeat (4) @(posedge ref_clk);
    chk("suspend", {cpu_halt, mem_refresh_en, cache_sleep}, 3'b111);
    chk("periph", periph_off, 1'b1);
    grant_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("sleep in grant", cache_sleep, 1'b0);
    ring_detect <= 1'b1;
    @(posedge ref_clk);
    ring_detect <= 1'b0;
    grant_req   <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("ring wake", {cpu_halt, periph_off, video_blank, disk_off}, 4'h0);
    // Three random reload lines, then the clock alarm, must each pull the system back to full.
    for (int i = 0; i < 4; i++) begin
      do k = $urandom % 16; while (!RELOAD_IRQ_OK[k]);
      repeat (20) @(posedge ref_clk);
      if (i < 3) irq_lines[k] <= 1'b1;
      else rtc_alarm <= 1'b1;
      @(posedge ref_clk);
      {rtc_alarm, irq_lines[k]} <= 2'b00;
      wb(0, IPSM_STATUS, 0);
      chk("reload", {q[18:16], 15'h0, q[15:0] <= 16'h1}, 19'h1);
    end
    // Thermal throttle at sel 4 keeps the cpu slowed 5 of every 8 cycles.
    wb(1, IPSM_CTRL, 32'h0004_2000);
    {fan_on, sys_activity} <= 2'b11;
    repeat (4) @(posedge ref_clk);
    cnt = 0;
    repeat (64) begin
      @(posedge ref_clk);
      cnt += (cpu_slow === 1'b1);
    end
    chk("duty", cnt, 40);
    {fan_on, sys_activity} <= 2'b00;
    // The button must be held the full time before the board goes off.
    wb(1, IPSM_CTRL, 32'h0004_011f);
    power_button_input <= 1'b1;
    repeat ((SOFT_OFF_MS - 10) * TL) @(posedge ref_clk);
    chk("early off", power_off, 1'b0);
    cnt = 0;
    while (power_off !== 1'b1 && cnt < 100 * TL) begin
      @(posedge ref_clk);
      cnt++;
    end
    repeat (3) @(posedge ref_clk);
    chk("soft off", {power_off, mem_refresh_en}, 2'b10);
    give_verdict();
  end
endmodule

bind ipsm_top ipsm_top_checker i_chk (
  .ref_clk        (ref_clk),
  .sys_rst        (sys_rst),
  .wb_cyc_i       (wb_cyc_i),
  .wb_stb_i       (wb_stb_i),
  .wb_dat_o       (wb_dat_o),
  .wb_ack_o       (wb_ack_o),
  .sys_activity   (sys_activity),
  .stop_grant     (stop_grant),
  .cpu_halt       (cpu_halt),
  .disk_off       (disk_off),
  .video_blank    (video_blank),
  .sync_off       (sync_off),
  .mem_refresh_en (mem_refresh_en),
  .cache_sleep    (cache_sleep),
  .power_off      (power_off)
);
